// >>> logic/gauge_port_pkg.sv
package gauge_port_pkg;

   // Bus address and command space.
   localparam logic [6:0] DEV_ADDR = 7'h55;
   localparam logic [7:0] CMD_LAST = 8'h6b;
   localparam logic [7:0] STATUS_CMD = 8'h6a;
   localparam logic [7:0] WR_LAST = 8'h69;
   localparam logic [6:0] STATUS_PAD = 7'h00;
   localparam logic STATUS_RESET = 1'b0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Timing.
   localparam int CLK_HZ = 100_000_000;
   localparam int TIMEOUT_S = 2;
   localparam int TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
   localparam int STRETCH_MS = 4;
   localparam int STRETCH_CYC = (CLK_HZ / 1000) * STRETCH_MS;

   // Write stream toward the command store.
   localparam int FIFO_DEPTH = 4;
   localparam int WORD_W = 16;

   typedef enum logic [2:0] {
      S_IDLE,
      S_ADDR,
      S_CMD,
      S_WR,
      S_RD,
      S_ACK,
      S_MACK
   } eng_t;

endpackage

// >>> logic/stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> logic/cmd_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module cmd_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   stream_if.snk wr,
   stream_if.src rd
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic room;
      logic avail;
      logic [WIDTH-1:0] head;
   } fifo_t;

   fifo_t s;
   fifo_t n;
   logic push;
   logic pop;

   always_comb
   begin
      n = s;
      push = wr.valid && s.room;
      pop = rd.ready && s.avail;
      if (push)
      begin
         n.mem[s.wp] = wr.data;
         n.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
      end
      if (pop)
      begin
         n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
      end
      if (push && !pop)
      begin
         n.cnt = s.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         n.cnt = s.cnt - 1'b1;
      end
      // Flags and head are registered so that both sides see flop outputs.
      n.room = (n.cnt < (AW+1)'(DEPTH));
      n.avail = (n.cnt != '0);
      n.head = n.mem[n.rp];
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
         s.room <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   assign wr.ready = s.room;
   assign rd.valid = s.avail;
   assign rd.data = s.head;

endmodule
`default_nettype wire

// >>> logic/gauge_i2c_command_port.sv
// Contract
// - Answer only bus address 1010101, that is 0xAA write and 0xAB read.
// - Support single, incremental and quick reads plus single and incremental writes.
// - A quick read returns the byte at the current address pointer.
// - Pointer advances by one on every acknowledged data byte, either side.
// - Successive written bytes land at consecutive command locations.
// - Data written to a read-only location is not acknowledged.
// - A command byte above 0x6B is not acknowledged.
// - Bus held low about 2 seconds releases both data and clock lines.
// - Lines still held low by others after release put the engine asleep.
// - Command 0x6a returns the profile status byte.
// - Status bit 0 is 0 for profile A last used, 1 for B; resets 0.
// - On insertion pick the matching dynamic profile, checking A then B.
// - With no match, copy default over the least recently used profile.
// - While the gauge sleeps, clock may be stretched up to 4 ms.
`timescale 1ns/1ns
`default_nettype none
module gauge_i2c_command_port
   import gauge_port_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int STRETCH_CYCLES = STRETCH_CYC,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic gauge_sleep,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic pack_insert,
   input wire logic match_a,
   input wire logic match_b,
   output logic last_profile_flag,
   output logic copy_default_a,
   output logic copy_default_b,
   output logic bus_released,
   output logic bus_sleep
);

   typedef struct packed {
      eng_t st;
      eng_t after;
      logic scl_q;
      logic sda_q;
      logic [2:0] bitcnt;
      logic done;
      logic macked;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic sda_lo;
      logic scl_lo;
      logic pin_lvl;
      logic [31:0] tcnt;
      logic [31:0] scnt;
      logic released;
      logic rel_d;
      logic bus_sleep;
      logic last;
      logic copy_a;
      logic copy_b;
      logic push;
      logic [WORD_W-1:0] push_word;
   } port_t;

   port_t s;
   port_t n;
   logic low;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic fifo_ready;
   logic [7:0] rd_byte;

   stream_if #(.WIDTH(WORD_W)) push_if ();
   stream_if #(.WIDTH(WORD_W)) pop_if ();

   always_comb
   begin
      n = s;
      n.copy_a = 1'b0;
      n.copy_b = 1'b0;
      n.push = 1'b0;
      n.scl_q = scl_in;
      n.sda_q = sda_in;
      n.rel_d = s.released;
      low = !scl_in || !sda_in;
      rise = !s.scl_q && scl_in;
      fall = s.scl_q && !scl_in;
      start = s.scl_q && scl_in && s.sda_q && !sda_in;
      stop = s.scl_q && scl_in && !s.sda_q && sda_in;
      // The status location is served here, all others from the store.
      if (s.ptr == STATUS_CMD)
      begin
         rd_byte = {STATUS_PAD, s.last};
      end
      else
      begin
         rd_byte = rd_data;
      end

      // Clock stretch ends when its count runs out.
      if (s.scnt != '0)
      begin
         n.scnt = s.scnt - 32'h1;
         if (s.scnt == 32'h1)
         begin
            n.scl_lo = 1'b0;
         end
      end

      if (start)
      begin
         n.st = S_ADDR;
         n.bitcnt = '0;
         n.done = 1'b0;
         n.sda_lo = 1'b0;
      end
      else if (stop)
      begin
         n.st = S_IDLE;
         n.sda_lo = 1'b0;
      end
      else
      begin
         case (s.st)
            S_ADDR, S_CMD, S_WR:
            begin
               if (rise)
               begin
                  n.shreg = {s.shreg[6:0], sda_in};
                  n.bitcnt = s.bitcnt + 3'h1;
                  n.done = (s.bitcnt == BIT_LAST);
               end
               else if (fall && s.done)
               begin
                  n.done = 1'b0;
                  n.st = S_ACK;
                  n.after = S_IDLE;
                  n.sda_lo = 1'b0;
                  if (s.st == S_ADDR)
                  begin
                     if (s.shreg[7:1] == DEV_ADDR)
                     begin
                        n.sda_lo = 1'b1;
                        n.after = s.shreg[0] ? S_RD : S_CMD;
                        if (gauge_sleep)
                        begin
                           n.scl_lo = 1'b1;
                           n.scnt = 32'(STRETCH_CYCLES);
                        end
                     end
                     else
                     begin
                        n.st = S_IDLE;
                     end
                  end
                  else if (s.st == S_CMD)
                  begin
                     if (s.shreg <= CMD_LAST)
                     begin
                        n.sda_lo = 1'b1;
                        n.ptr = s.shreg;
                        n.after = S_WR;
                     end
                  end
                  else if (s.ptr <= WR_LAST && fifo_ready)
                  begin
                     n.sda_lo = 1'b1;
                     n.push = 1'b1;
                     n.push_word = {s.ptr, s.shreg};
                     n.ptr = s.ptr + 8'h1;
                     n.after = S_WR;
                  end
               end
            end
            S_ACK:
            begin
               if (fall)
               begin
                  n.bitcnt = '0;
                  n.st = s.after;
                  n.sda_lo = 1'b0;
                  if (s.after == S_RD)
                  begin
                     n.shreg = rd_byte;
                     n.sda_lo = !rd_byte[7];
                  end
               end
            end
            S_RD:
            begin
               if (fall)
               begin
                  n.shreg = {s.shreg[6:0], 1'b0};
                  n.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == BIT_LAST)
                  begin
                     n.sda_lo = 1'b0;
                     n.st = S_MACK;
                  end
                  else
                  begin
                     n.sda_lo = !s.shreg[6];
                  end
               end
            end
            S_MACK:
            begin
               if (rise)
               begin
                  n.macked = !sda_in;
                  if (!sda_in)
                  begin
                     n.ptr = s.ptr + 8'h1;
                  end
               end
               else if (fall)
               begin
                  if (s.macked)
                  begin
                     n.st = S_RD;
                     n.bitcnt = '0;
                     n.shreg = rd_byte;
                     n.sda_lo = !rd_byte[7];
                  end
                  else
                  begin
                     n.st = S_IDLE;
                  end
               end
            end
            default:
            begin
               n.st = s.st;
            end
         endcase
      end

      // Stuck-bus watchdog and release.
      if (!low)
      begin
         n.tcnt = '0;
         n.released = 1'b0;
         n.bus_sleep = 1'b0;
      end
      else if (!s.released)
      begin
         n.tcnt = s.tcnt + 32'h1;
         if (s.tcnt == 32'(TIMEOUT_CYCLES - 1))
         begin
            n.released = 1'b1;
         end
      end
      if (n.released)
      begin
         n.st = S_IDLE;
         n.sda_lo = 1'b0;
         n.scl_lo = 1'b0;
         n.scnt = '0;
      end
      if (s.rel_d && s.released && low)
      begin
         n.bus_sleep = 1'b1;
      end

      // Profile choice on pack insertion.
      if (pack_insert)
      begin
         if (match_a)
         begin
            n.last = 1'b0;
         end
         else if (match_b)
         begin
            n.last = 1'b1;
         end
         else
         begin
            n.copy_a = s.last;
            n.copy_b = !s.last;
            n.last = !s.last;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
         s.st <= S_IDLE;
         s.after <= S_IDLE;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
         s.last <= STATUS_RESET;
      end
      else
      begin
         s <= n;
      end
   end

   cmd_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr(push_if.snk),
      .rd(pop_if.src)
   );

   assign push_if.valid = s.push;
   assign push_if.data = s.push_word;
   assign fifo_ready = push_if.ready;
   assign pop_if.ready = wr_ready;
   assign wr_valid = pop_if.valid;
   assign wr_addr = pop_if.data[WORD_W-1:8];
   assign wr_data = pop_if.data[7:0];

   assign scl_out = s.pin_lvl;
   assign sda_out = s.pin_lvl;
   assign scl_oe = s.scl_lo;
   assign sda_oe = s.sda_lo;
   assign rd_addr = s.ptr;
   assign last_profile_flag = s.last;
   assign copy_default_a = s.copy_a;
   assign copy_default_b = s.copy_b;
   assign bus_released = s.released;
   assign bus_sleep = s.bus_sleep;

   // Checks.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_addr_mismatch: assert property (
      (s.st == S_ADDR && fall && s.done && !start && !stop && !n.released
       && s.shreg[7:1] != DEV_ADDR) |=> (s.st == S_IDLE && !sda_oe))
      else $error("Foreign address was answered.");

   a_read_ptr_step: assert property (
      (s.st == S_MACK && rise && !sda_in && !start && !stop && !n.released)
      |=> (rd_addr == $past(rd_addr) + 8'h1))
      else $error("Pointer did not advance after master acknowledge.");

   a_ro_write_nack: assert property (
      (s.st == S_WR && fall && s.done && s.ptr > WR_LAST)
      |=> (!sda_oe && !s.push))
      else $error("Write to read-only location was acknowledged.");

   a_cmd_range_nack: assert property (
      (s.st == S_CMD && fall && s.done && !start && !stop
       && s.shreg > CMD_LAST) |=> (!sda_oe && s.after == S_IDLE))
      else $error("Out of range command was acknowledged.");

   a_timeout_release: assert property (
      (low && !s.released && s.tcnt == 32'(TIMEOUT_CYCLES - 1))
      |=> (bus_released && !sda_oe && !scl_oe))
      else $error("Stuck bus did not release the lines.");

   a_sleep_entry: assert property (
      (bus_released && low) ##1 (bus_released && low) |=> bus_sleep)
      else $error("Engine did not sleep with bus held low.");

   a_profile_match: assert property (
      (pack_insert && match_a) |=> (!last_profile_flag && !copy_default_a
                                    && !copy_default_b))
      else $error("Matching profile A was not chosen.");

   a_profile_lru: assert property (
      (pack_insert && !match_a && !match_b) |=>
         (last_profile_flag != $past(last_profile_flag)
          && copy_default_a == $past(last_profile_flag)
          && copy_default_b != $past(last_profile_flag)))
      else $error("Default was not copied over the older profile.");

endmodule
`default_nettype wire

// >>> test/bus_master.sv
`timescale 1ns/1ns
`default_nettype none
module bus_master (
   input wire logic clk_sys,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic scl_out,
   input wire logic sda_out,
   output logic scl_in,
   output logic sda_in
);
   logic m_scl = 1'b1;
   logic m_sda = 1'b1;
   logic stretched = 1'b0;

   // Open-drain lines with pull-ups: low while either side pulls.
   assign scl_in = m_scl & (scl_out | ~scl_oe);
   assign sda_in = m_sda & (sda_out | ~sda_oe);

   task automatic half();
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic bit_io(input logic b, output logic r);
      int n;
      m_sda <= b;
      half();
      m_scl <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (scl_in !== 1'b1 && n < 1000)
      begin
         stretched = 1'b1;
         n++;
         @(posedge clk_sys);
      end
      half();
      r = sda_in;
      m_scl <= 1'b0;
   endtask

   task automatic start();
      m_sda <= 1'b1;
      half();
      m_scl <= 1'b1;
      half();
      m_sda <= 1'b0;
      half();
      m_scl <= 1'b0;
   endtask

   task automatic stop();
      m_sda <= 1'b0;
      half();
      m_scl <= 1'b1;
      half();
      m_sda <= 1'b1;
      half();
   endtask

   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic recv(input logic mack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(~mack, r);
   endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
   logic gauge_sleep = 1'b0;
   logic wr_ready = 1'b0;
   logic pack_insert = 1'b0;
   logic match_a = 1'b0;
   logic match_b = 1'b0;
   logic [7:0] rd_addr, rd_data, wr_addr, wr_data, d;
   logic wr_valid, last_profile_flag, copy_default_a, copy_default_b;
   logic bus_released, bus_sleep, ack;
   logic [7:0] n_copy_a = 8'h00;
   logic [7:0] n_copy_b = 8'h00;
   int n_errors = 0;
   int check_count = 0;

   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end

   // Read store answers a fixed function of the pointer.
   assign rd_data = rd_addr ^ 8'h3c;

   always @(posedge clk_sys)
   begin
      n_copy_a <= n_copy_a + {7'h0, copy_default_a};
      n_copy_b <= n_copy_b + {7'h0, copy_default_b};
   end

   gauge_i2c_command_port #(.TIMEOUT_CYCLES(256), .STRETCH_CYCLES(8))
      i_gauge_i2c_command_port (.clk_sys, .rst, .scl_in, .scl_out, .scl_oe,
      .sda_in, .sda_out, .sda_oe, .gauge_sleep, .rd_addr, .rd_data,
      .wr_valid, .wr_ready, .wr_addr, .wr_data, .pack_insert, .match_a,
      .match_b, .last_profile_flag, .copy_default_a, .copy_default_b,
      .bus_released, .bus_sleep);

   bus_master i_bus_master (.clk_sys, .scl_oe, .sda_oe, .scl_out, .sda_out,
      .scl_in, .sda_in);

   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic tx(input logic [7:0] b, input logic exp_ack);
      i_bus_master.send(b, ack);
      check("ack", {7'h0, exp_ack}, {7'h0, ack});
   endtask

   task automatic t_fifo();
      i_bus_master.start();
      tx(8'haa, 1'b1);
      tx(8'h10, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         tx(8'ha0 + i[7:0], 1'b1);
      end
      tx(8'hbb, 1'b0);
      i_bus_master.stop();
      check("pointer", 8'h14, rd_addr);
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk_sys);
         check("head valid", 8'h01, {7'h0, wr_valid});
         check("head addr", 8'h10 + i[7:0], wr_addr);
         check("head data", 8'ha0 + i[7:0], wr_data);
         @(posedge clk_sys);
         wr_ready <= 1'b1;
         @(posedge clk_sys);
         wr_ready <= 1'b0;
         @(posedge clk_sys);
      end
      @(negedge clk_sys);
      check("drained", 8'h00, {7'h0, wr_valid});
      @(posedge clk_sys);
   endtask

   task automatic t_refuse();
      i_bus_master.start();
      tx(8'h52, 1'b0);
      i_bus_master.stop();
      i_bus_master.start();
      tx(8'haa, 1'b1);
      tx(8'h6c, 1'b0);
      i_bus_master.stop();
      i_bus_master.start();
      tx(8'haa, 1'b1);
      tx(8'h6b, 1'b1);
      tx(8'h55, 1'b0);
      i_bus_master.stop();
      check("no push", 8'h00, {7'h0, wr_valid});
      check("pointer", 8'h6b, rd_addr);
   endtask

   task automatic t_quick();
      i_bus_master.start();
      tx(8'haa, 1'b1);
      tx(8'h20, 1'b1);
      i_bus_master.stop();
      i_bus_master.start();
      tx(8'hab, 1'b1);
      i_bus_master.recv(1'b1, d);
      check("quick 0", 8'h20 ^ 8'h3c, d);
      i_bus_master.recv(1'b0, d);
      check("quick 1", 8'h21 ^ 8'h3c, d);
      i_bus_master.stop();
      check("pointer", 8'h21, rd_addr);
   endtask

   task automatic read_status(input logic [7:0] exp);
      i_bus_master.start();
      tx(8'haa, 1'b1);
      tx(8'h6a, 1'b1);
      i_bus_master.start();
      tx(8'hab, 1'b1);
      i_bus_master.recv(1'b0, d);
      i_bus_master.stop();
      check("status", exp, d);
   endtask

   task automatic insert(input logic ma, input logic mb);
      pack_insert <= 1'b1;
      match_a <= ma;
      match_b <= mb;
      @(posedge clk_sys);
      pack_insert <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic t_profile();
      read_status(8'h00);
      insert(1'b0, 1'b0);
      check("copy b", 8'h01, n_copy_b);
      read_status(8'h01);
      insert(1'b0, 1'b0);
      check("copy a", 8'h01, n_copy_a);
      check("flag", 8'h00, {7'h0, last_profile_flag});
      insert(1'b0, 1'b1);
      check("flag", 8'h01, {7'h0, last_profile_flag});
      insert(1'b1, 1'b1);
      check("flag", 8'h00, {7'h0, last_profile_flag});
      check("copies", 8'h02, n_copy_a + n_copy_b);
   endtask

   task automatic t_stretch();
      gauge_sleep <= 1'b1;
      i_bus_master.stretched = 1'b0;
      i_bus_master.start();
      tx(8'haa, 1'b1);
      tx(8'h30, 1'b1);
      i_bus_master.stop();
      gauge_sleep <= 1'b0;
      check("stretch", 8'h01, {7'h0, i_bus_master.stretched});
      check("pin level", 8'h00, {6'h0, scl_out, sda_out});
   endtask

   task automatic t_timeout();
      i_bus_master.m_sda <= 1'b0;
      repeat (270) @(posedge clk_sys);
      check("released", 8'h01, {7'h0, bus_released});
      check("oe", 8'h00, {6'h0, scl_oe, sda_oe});
      check("sleep", 8'h01, {7'h0, bus_sleep});
      i_bus_master.m_sda <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("cleared", 8'h00, {6'h0, bus_released, bus_sleep});
   endtask

   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check("reset flag", 8'h00, {7'h0, last_profile_flag});
      check("reset pointer", 8'h00, rd_addr);
      t_fifo();
      t_refuse();
      t_quick();
      t_profile();
      t_stretch();
      t_timeout();
      test_done();
   end

   initial
   begin
      repeat (50000) @(posedge clk_sys);
      n_errors++;
      test_done();
   end
endmodule
`default_nettype wire
